// ### hw/vso_pkg.sv
// constants, types and register map of the voltage setpoint and local overvoltage block
// assumes one 100 mhz clock; adc codes arrive on that clock, no synchronising needed
// How it works
// R01: the active remote setpoint is the target that the remote sense difference is regulated to.
// R02: the target rises by one fixed step (0.6 percent of nominal) per setpoint code.
// R03: the remote setpoint comes out of reset at code a5, meaning 100 percent of nominal.
// R04: a host write to the setpoint lands in a shadow copy and leaves the active value alone.
// R05: setting the commit bit copies the shadow value into the active setpoint.
// R06: the local limit is a 5-bit code in bits 7 to 3, 107.7 percent at zero, 1.21 percent a step.
// R07: the trip threshold is (89 + code) / 128 of the 1.55 v adc full scale, as an adc code.
// R08: the local sense is averaged over each 80 us period and that average is compared.
// R09: with more than one sample selected, every one of the consecutive periods must be above.
// R10: the 2-bit sample count field needs one, two, three or four periods above the threshold.
// R11: the commit bit clears itself once the shadow value has been copied.
package vso_pkg;

  localparam int ADC_W = 12;
  localparam int FRAC_W = 7;
  localparam int CLK_MHZ = 100;
  localparam int PERIOD_US = 80;
  localparam int PERIOD_CYC = PERIOD_US * CLK_MHZ;
  localparam int CNT_W = 14;
  localparam int SUM_W = ADC_W + CNT_W;
  localparam int ADDR_W = 12;

  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_SETPOINT = 10'h031;
  localparam logic [9:0] IDX_LIMIT = 10'h032;
  localparam logic [9:0] IDX_STATUS = 10'h040;
  localparam logic [9:0] IDX_MASK = 10'h041;
  localparam logic [9:0] IDX_ACTIVE = 10'h042;
  localparam logic [9:0] IDX_COMMIT = 10'h05d;

  localparam logic [7:0] SETPOINT_RST = 8'ha5;
  localparam logic [7:0] LIMIT_RST = 8'h00;
  localparam logic [1:0] MASK_RST = 2'h0;
  localparam logic [ADC_W:0] THR_BASE = 13'h059;

  localparam int LIM_CODE_LO = 3;
  localparam int LIM_CODE_HI = 7;
  localparam int LIM_CNT_HI = 1;
  localparam int COMMIT_BIT = 0;
  localparam int ST_TRIP = 0;
  localparam int ST_COMMIT = 1;
  localparam int STEP_SHIFT = ADC_W - 8;

  typedef struct packed {
    logic valid;
    logic [ADC_W-1:0] code;
  } vso_sample_type;

  typedef enum {
    APB_IDLE,
    APB_WAIT,
    APB_DONE
  } vso_apb_state_type;

  function automatic logic [ADDR_W-1:0] byte_addr(input logic [9:0] idx);
    byte_addr = {idx, 2'b00};
  endfunction

  // adc code of (89 + code) / 128 of full scale
  function automatic logic [ADC_W:0] limit_threshold(input logic [4:0] code);
    limit_threshold = (THR_BASE + {8'h00, code}) << (ADC_W - FRAC_W);
  endfunction

endpackage : vso_pkg

// ### hw/vso_avg.sv
// running sum and sample count of the local sense over one averaging period
// assumes period_end is a one-cycle pulse from the owner's period timer
module vso_avg (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // samples and period marker
  input vso_pkg::vso_sample_type sample,
  input wire logic period_end,
  // period totals
  output logic [vso_pkg::SUM_W-1:0] sum_q,
  output logic [vso_pkg::CNT_W-1:0] cnt_q,
  output logic done_q
);

  logic [vso_pkg::SUM_W-1:0] acc_q;
  logic [vso_pkg::CNT_W-1:0] num_q;
  logic [vso_pkg::SUM_W-1:0] add;

  assign add = sample.valid ? {{vso_pkg::CNT_W{1'b0}}, sample.code} : '0;

  // the sample of the closing cycle still belongs to the closing period
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      acc_q <= '0;
      num_q <= '0;
      sum_q <= '0;
      cnt_q <= '0;
    end else if (ce) begin
      if (period_end) begin
        sum_q <= acc_q + add;
        cnt_q <= num_q + {{(vso_pkg::CNT_W-1){1'b0}}, sample.valid};
        acc_q <= '0;
        num_q <= '0;
      end else begin
        acc_q <= acc_q + add;
        num_q <= num_q + {{(vso_pkg::CNT_W-1){1'b0}}, sample.valid};
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      done_q <= 1'b0;
    end else if (ce) begin
      done_q <= period_end;
    end
  end

endmodule // vso_avg

// ### hw/vso_top.sv
// apb register bank, setpoint commit and local overvoltage qualification
// assumes adc codes and apb run on clock; ce low freezes everything
module vso_top #(
  parameter int PERIOD_CYCLES = vso_pkg::PERIOD_CYC
) (
  // clock, reset, enable
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [vso_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready_q,
  output logic [31:0] prdata_q,
  output logic pslverr_q,
  // sense codes
  input vso_pkg::vso_sample_type local_sense,
  input vso_pkg::vso_sample_type remote_sense_pos,
  input vso_pkg::vso_sample_type remote_sense_neg,
  // regulation and protection
  output logic [7:0] remote_target_q,
  output logic signed [vso_pkg::ADC_W+1:0] remote_error_q,
  output logic overvoltage_trip_q,
  output logic irq_q
);

  vso_pkg::vso_apb_state_type apb_q;
  logic [7:0] shadow_q;
  logic [7:0] limit_q;
  logic commit_q;
  logic [1:0] status_q;
  logic [1:0] status_d;
  logic [1:0] mask_q;
  logic [1:0] rd_clear_q;
  logic [vso_pkg::CNT_W-1:0] per_cnt_q;
  logic period_end;
  logic [vso_pkg::SUM_W-1:0] sum;
  logic [vso_pkg::CNT_W-1:0] cnt;
  logic done;
  logic [vso_pkg::ADC_W:0] thr;
  logic above;
  logic [1:0] runs_q;
  logic qualify;
  logic acc;
  logic wr;
  logic [9:0] idx;
  logic [1:0] events;

  assign idx = paddr[vso_pkg::ADDR_W-1:2];
  assign acc = (apb_q == vso_pkg::APB_DONE) && psel && penable;
  assign wr = acc && pwrite;

  // apb: answer in the second access cycle, writes act on the sampled edge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      apb_q <= vso_pkg::APB_IDLE;
    end else if (ce) begin
      case (apb_q)
        vso_pkg::APB_IDLE: if (psel && !penable) apb_q <= vso_pkg::APB_WAIT;
        vso_pkg::APB_WAIT: if (psel && penable) apb_q <= vso_pkg::APB_DONE;
        vso_pkg::APB_DONE: apb_q <= vso_pkg::APB_IDLE;
        default: apb_q <= vso_pkg::APB_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pready_q <= 1'b0;
      prdata_q <= '0;
      pslverr_q <= 1'b0;
      rd_clear_q <= '0;
    end else if (ce) begin
      pready_q <= (apb_q == vso_pkg::APB_WAIT) && psel && penable;
      rd_clear_q <= '0;
      if ((apb_q == vso_pkg::APB_WAIT) && psel && penable) begin
        prdata_q <= '0;
        pslverr_q <= 1'b0;
        case (paddr)
          vso_pkg::byte_addr(vso_pkg::IDX_SETPOINT): prdata_q[7:0] <= shadow_q;
          vso_pkg::byte_addr(vso_pkg::IDX_LIMIT): prdata_q[7:0] <= limit_q;
          vso_pkg::byte_addr(vso_pkg::IDX_ACTIVE): prdata_q[7:0] <= remote_target_q;
          vso_pkg::byte_addr(vso_pkg::IDX_MASK): prdata_q[1:0] <= mask_q;
          vso_pkg::byte_addr(vso_pkg::IDX_COMMIT): prdata_q[vso_pkg::COMMIT_BIT] <= commit_q;
          vso_pkg::byte_addr(vso_pkg::IDX_STATUS): begin
            prdata_q[1:0] <= status_q;
            // only the bits returned are cleared, so a later event survives
            if (!pwrite) rd_clear_q <= status_q;
          end
          default: pslverr_q <= 1'b1;
        endcase
      end
    end
  end

  // setpoint shadow and commit
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      shadow_q <= vso_pkg::SETPOINT_RST; // [R03]
    end else if (ce && wr && paddr == vso_pkg::byte_addr(vso_pkg::IDX_SETPOINT)) begin
      shadow_q <= pwdata[7:0]; // [R04]
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      commit_q <= 1'b0;
    end else if (ce) begin
      if (wr && paddr == vso_pkg::byte_addr(vso_pkg::IDX_COMMIT)
          && pwdata[vso_pkg::COMMIT_BIT]) begin
        commit_q <= 1'b1; // [R05]
      end else if (commit_q) begin
        commit_q <= 1'b0; // [R11]
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      remote_target_q <= vso_pkg::SETPOINT_RST; // [R03]
    end else if (ce && commit_q) begin
      remote_target_q <= shadow_q; // [R05]
    end
  end

  // target in adc units: one code is one fixed step of the scale
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      remote_error_q <= '0;
    end else if (ce && remote_sense_pos.valid && remote_sense_neg.valid) begin
      remote_error_q <= $signed({2'b00, remote_sense_pos.code})
        - $signed({2'b00, remote_sense_neg.code})
        - $signed({2'b00, remote_target_q, {vso_pkg::STEP_SHIFT{1'b0}}}); // [R01] [R02]
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      limit_q <= vso_pkg::LIMIT_RST;
    end else if (ce && wr && paddr == vso_pkg::byte_addr(vso_pkg::IDX_LIMIT)) begin
      limit_q <= pwdata[7:0]; // [R06]
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mask_q <= vso_pkg::MASK_RST;
    end else if (ce && wr && paddr == vso_pkg::byte_addr(vso_pkg::IDX_MASK)) begin
      mask_q <= pwdata[1:0];
    end
  end

  // averaging period timer
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      per_cnt_q <= '0;
    end else if (ce) begin
      per_cnt_q <= period_end ? '0 : per_cnt_q + 1'b1; // [R08]
    end
  end

  assign period_end = (per_cnt_q == vso_pkg::CNT_W'(PERIOD_CYCLES - 1));

  vso_avg u_avg (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .sample(local_sense),
    .period_end(period_end),
    .sum_q(sum),
    .cnt_q(cnt),
    .done_q(done)
  );

  assign thr = vso_pkg::limit_threshold(limit_q[vso_pkg::LIM_CODE_HI:vso_pkg::LIM_CODE_LO]); // [R07]
  // sum > thr * count avoids a divider; a period with no samples never trips
  assign above = (cnt != '0)
    && (sum > vso_pkg::SUM_W'(thr) * vso_pkg::SUM_W'(cnt)); // [R08]
  assign qualify = done && above && (runs_q >= limit_q[vso_pkg::LIM_CNT_HI:0]); // [R10]

  // consecutive periods above the threshold, saturating at three
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      runs_q <= '0;
    end else if (ce && done) begin
      if (!above) begin
        runs_q <= '0; // [R09]
      end else if (runs_q != 2'h3) begin
        runs_q <= runs_q + 1'b1; // [R09]
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      overvoltage_trip_q <= 1'b0;
    end else if (ce && done) begin
      overvoltage_trip_q <= qualify; // [R09] [R10]
    end
  end

  // sticky events; a new event beats a read clear in the same cycle
  assign events[vso_pkg::ST_TRIP] = qualify && !overvoltage_trip_q;
  assign events[vso_pkg::ST_COMMIT] = commit_q;
  assign status_d = (status_q & ~rd_clear_q) | events;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      status_q <= '0;
      irq_q <= 1'b0;
    end else if (ce) begin
      status_q <= status_d;
      irq_q <= |(status_d & mask_q);
    end
  end

  chk_commit_copy: assert property (@(posedge clock) disable iff (rst) // [R05] [R11]
    ce && commit_q |=> remote_target_q == $past(shadow_q) && !commit_q)
    else $error("commit did not copy shadow or did not clear");

  chk_shadow_only: assert property (@(posedge clock) disable iff (rst) // [R04]
    ce && !commit_q |=> remote_target_q == $past(remote_target_q))
    else $error("active setpoint moved without commit");

  chk_limit_threshold: assert property (@(posedge clock) disable iff (rst) // [R07]
    thr == 13'hb20 + {3'h0, limit_q[7:3], 5'h00})
    else $error("threshold code wrong");

  chk_period_spacing: assert property (@(posedge clock) disable iff (rst || !ce) // [R08]
    period_end |=> !period_end [*2])
    else $error("period ends too close");

  chk_below_resets: assert property (@(posedge clock) disable iff (rst) // [R09]
    ce && done && !above |=> runs_q == 2'h0 && !overvoltage_trip_q)
    else $error("period below threshold did not reset qualification");

  chk_one_sample: assert property (@(posedge clock) disable iff (rst) // [R10]
    ce && done && above && limit_q[1:0] == 2'h0 |=> overvoltage_trip_q)
    else $error("single sample did not trip");

  chk_four_needed: assert property (@(posedge clock) disable iff (rst) // [R10]
    ce && done && limit_q[1:0] == 2'h3 && runs_q != 2'h3 |=> !overvoltage_trip_q)
    else $error("tripped before four periods");

  chk_error_target: assert property (@(posedge clock) disable iff (rst) // [R01] [R02]
    ce && remote_sense_pos.valid && remote_sense_neg.valid && remote_sense_pos.code ==
    remote_sense_neg.code |=> remote_error_q == -$signed({2'b00, $past(remote_target_q), 4'h0}))
    else $error("remote error not against target");

  chk_pready_pulse: assert property (@(posedge clock) disable iff (rst || !ce)
    pready_q |=> !pready_q)
    else $error("pready held more than one cycle");

  chk_trip_event: assert property (@(posedge clock) disable iff (rst)
    ce && events[0] |=> status_q[0])
    else $error("trip event lost");

  chk_status_sticky: assert property (@(posedge clock) disable iff (rst)
    ce && status_q[0] && !rd_clear_q[0] |=> status_q[0])
    else $error("trip status dropped without a read");

  chk_irq_level: assert property (@(posedge clock) disable iff (rst)
    ce && !wr |=> irq_q == |(status_q & mask_q))
    else $error("irq does not follow masked status");

  chk_target_reset: assert property (@(posedge clock) // [R03]
    rst |=> remote_target_q == vso_pkg::SETPOINT_RST)
    else $error("active setpoint not at default after reset");

  chk_shadow_write: assert property (@(posedge clock) disable iff (rst) // [R04]
    ce && wr && paddr == vso_pkg::byte_addr(vso_pkg::IDX_SETPOINT) |=> shadow_q == $past(pwdata[7:0]))
    else $error("setpoint write did not reach shadow");

  chk_commit_set: assert property (@(posedge clock) disable iff (rst) // [R05]
    ce && wr && paddr == vso_pkg::byte_addr(vso_pkg::IDX_COMMIT) && pwdata[0] |=> commit_q)
    else $error("commit write did not set commit");

  chk_limit_write: assert property (@(posedge clock) disable iff (rst) // [R06]
    ce && wr && paddr == vso_pkg::byte_addr(vso_pkg::IDX_LIMIT) |=> limit_q == $past(pwdata[7:0]))
    else $error("limit write not stored");

  chk_trip_hold: assert property (@(posedge clock) disable iff (rst) // [R08]
    !(ce && done) |=> $stable(overvoltage_trip_q))
    else $error("trip changed outside a period evaluation");

  chk_runs_count: assert property (@(posedge clock) disable iff (rst) // [R09]
    ce && done && above && runs_q != 2'h3 |=> runs_q == $past(runs_q) + 2'h1)
    else $error("consecutive period count did not advance");

  chk_trip_two: assert property (@(posedge clock) disable iff (rst) // [R10]
    ce && done && above && limit_q[1:0] == 2'h1 && runs_q == 2'h0 |=> !overvoltage_trip_q)
    else $error("tripped on first of two periods");

  cov_commit: cover property (@(posedge clock) disable iff (rst) commit_q ##1 !commit_q);
  cov_trip_four: cover property (@(posedge clock) disable iff (rst)
    qualify && limit_q[1:0] == 2'h3);
  cov_irq: cover property (@(posedge clock) disable iff (rst) !irq_q ##1 irq_q);
  cov_slverr: cover property (@(posedge clock) disable iff (rst) pready_q && pslverr_q);
  cov_status_clear: cover property (@(posedge clock) disable iff (rst) status_q[0] ##1 !status_q[0]);

endmodule // vso_top

// ### dv/vso_tb.sv
// self-checking bench for the setpoint register bank and local overvoltage trip
// assumes vso_pkg is compiled first; the averaging period is shortened to 16 cycles
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int P = 16;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic pready_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  vso_pkg::vso_sample_type local_sense = '0;
  vso_pkg::vso_sample_type remote_sense_pos = '0;
  vso_pkg::vso_sample_type remote_sense_neg = '0;
  logic [7:0] remote_target_q;
  logic signed [13:0] remote_error_q;
  logic overvoltage_trip_q;
  logic irq_q;
  int n_fail = 0;
  int n_checks = 0;
  logic [31:0] rdat;
  logic rerr;

  always #5 clock = ~clock;

  vso_top #(.PERIOD_CYCLES(P)) u_vso_top (
    .clock(clock), .rst(rst), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready_q(pready_q), .prdata_q(prdata_q), .pslverr_q(pslverr_q),
    .local_sense(local_sense), .remote_sense_pos(remote_sense_pos),
    .remote_sense_neg(remote_sense_neg), .remote_target_q(remote_target_q),
    .remote_error_q(remote_error_q), .overvoltage_trip_q(overvoltage_trip_q), .irq_q(irq_q)
  );

  task automatic close_out();
    if (n_fail == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      $display("BAD %s expected %h seen %h", name, exp, seen);
      n_fail++;
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready_q !== 1'b1 && n < 50) begin
      @(posedge clock);
      n++;
    end
    if (n >= 50) begin
      n_fail++;
    end
    rdat = prdata_q;
    rerr = pslverr_q;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rd_chk(input string name, input logic [9:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    check(name, rdat, exp);
  endtask

  // clear with low samples, then hold val and time the trip against the sample count
  task automatic trip_run(input logic [4:0] code, input logic [1:0] cnt,
                          input logic [11:0] val, input logic exp);
    local_sense <= '{valid: 1'b1, code: 12'h000};
    repeat (3 * P) @(posedge clock);
    check("trip cleared", {31'h0, overvoltage_trip_q}, 32'h0);
    apb(1'b1, vso_pkg::IDX_LIMIT, {24'h0, code, 1'b0, cnt});
    local_sense <= '{valid: 1'b1, code: val};
    repeat ((cnt + 1) * P - 2) @(posedge clock);
    check("trip early", {31'h0, overvoltage_trip_q}, 32'h0);
    repeat (P + 6) @(posedge clock);
    check("trip late", {31'h0, overvoltage_trip_q}, {31'h0, exp});
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    close_out();
  end

  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    check("target reset", {24'h0, remote_target_q}, 32'ha5);
    rd_chk("shadow reset", vso_pkg::IDX_SETPOINT, 32'ha5);
    rd_chk("limit reset", vso_pkg::IDX_LIMIT, 32'h0);
    rd_chk("mask reset", vso_pkg::IDX_MASK, 32'h0);
    apb(1'b1, vso_pkg::IDX_SETPOINT, 32'h40);
    check("target held", {24'h0, remote_target_q}, 32'ha5);
    rd_chk("active held", vso_pkg::IDX_ACTIVE, 32'ha5);
    rd_chk("shadow", vso_pkg::IDX_SETPOINT, 32'h40);
    apb(1'b1, vso_pkg::IDX_COMMIT, 32'h1);
    repeat (2) @(posedge clock);
    check("target commit", {24'h0, remote_target_q}, 32'h40);
    rd_chk("commit self clear", vso_pkg::IDX_COMMIT, 32'h0);
    check("irq masked", {31'h0, irq_q}, 32'h0);
    rd_chk("status commit", vso_pkg::IDX_STATUS, 32'h2);
    rd_chk("status cleared", vso_pkg::IDX_STATUS, 32'h0);
    apb(1'b1, vso_pkg::IDX_SETPOINT, 32'h10);
    repeat (4) @(posedge clock);
    check("no fresh commit", {24'h0, remote_target_q}, 32'h40);
    // 0x40 codes of 16 adc steps each: 0x410 - 0x020 - 0x400 = -16
    remote_sense_pos <= '{valid: 1'b1, code: 12'h410};
    remote_sense_neg <= '{valid: 1'b1, code: 12'h020};
    repeat (4) @(posedge clock);
    check("remote error", 32'(remote_error_q), 32'hfffffff0);
    // equal sense inputs leave only the target: -(0x40 * 16)
    remote_sense_neg <= '{valid: 1'b1, code: 12'h410};
    repeat (4) @(posedge clock);
    check("remote error target", 32'(remote_error_q), 32'hfffffc00);
    // ce low must freeze the error register against a new sample
    ce <= 1'b0;
    remote_sense_neg <= '{valid: 1'b1, code: 12'h020};
    repeat (4) @(posedge clock);
    check("ce freeze", 32'(remote_error_q), 32'hfffffc00);
    ce <= 1'b1;
    @(posedge clock);
    rd_chk("unmapped data", 10'h3ff, 32'h0);
    check("unmapped err", {31'h0, rerr}, 32'h1);
    apb(1'b1, vso_pkg::IDX_LIMIT, 32'hfe);
    rd_chk("limit fields", vso_pkg::IDX_LIMIT, 32'hfe);
    apb(1'b1, vso_pkg::IDX_MASK, 32'h1);
    rd_chk("mask", vso_pkg::IDX_MASK, 32'h1);
    // code 0 threshold is 89 * 32 = 0xb20; one above it must trip
    for (int c = 0; c < 4; c++) begin
      trip_run(5'd0, 2'(c), 12'hb21, 1'b1);
      check("irq trip", {31'h0, irq_q}, 32'h1);
      rd_chk("status trip", vso_pkg::IDX_STATUS, 32'h1);
      @(posedge clock);
      check("irq after read", {31'h0, irq_q}, 32'h0);
    end
    // code 31 threshold is 120 * 32 = 0xf00; equal is not above
    trip_run(5'd31, 2'd0, 12'hf00, 1'b0);
    trip_run(5'd31, 2'd0, 12'hf01, 1'b1);
    close_out();
  end
endmodule // tb
